// >>> rtl/rcs_defs.svh
`ifndef RCS_DEFS_SVH
`define RCS_DEFS_SVH

// register byte offsets
`define RCS_OFF_OPER_COND 8'h00
`define RCS_OFF_OPER_EVENT 8'h04
`define RCS_OFF_OPER_MASK 8'h08
`define RCS_OFF_QUES_COND 8'h0C
`define RCS_OFF_QUES_EVENT 8'h10
`define RCS_OFF_QUES_MASK 8'h14
`define RCS_OFF_STATUS_BYTE 8'h18
`define RCS_OFF_BUS_ADDR 8'h1C
`define RCS_OFF_COMMAND 8'h20
`define RCS_OFF_LAN_CTRL 8'h24
`define RCS_OFF_LAN_IP 8'h28
`define RCS_OFF_LAN_MASK 8'h2C
`define RCS_OFF_MAC_LO 8'h30
`define RCS_OFF_MAC_HI 8'h34
`define RCS_OFF_LAN_INDEX 8'h38
`define RCS_OFF_SER_BAUD 8'h3C
`define RCS_OFF_SER_ECHO 8'h40

// field positions
`define RCS_OPER_CV_BIT 8
`define RCS_OPER_CC_BIT 10
`define RCS_QUES_VM_BIT 0
`define RCS_QUES_CM_BIT 1
`define RCS_QUES_VE_BIT 12
`define RCS_QUES_CE_BIT 13
`define RCS_SB_QUES_BIT 3
`define RCS_SB_OPER_BIT 7
`define RCS_CMD_SAVE_BIT 0
`define RCS_CMD_LAN_RST_BIT 1
`define RCS_LAN_DHCP_BIT 0
`define RCS_LAN_AUTO_BIT 1

// latch masks and limits
`define RCS_OPER_LATCH 16'hFFFF
`define RCS_QUES_LATCH 16'h3000
`define RCS_BUS_ADDR_MAX 5'h1E
`define RCS_INDEX_MIN 7'h01
`define RCS_INDEX_MAX 7'h63
`define RCS_LINE_TERM 8'h0A

// reset values
`define RCS_RST_INDEX 7'h01
`define RCS_RST_BUS_ADDR 5'h00

// serial rates and divider counts
`define RCS_CLK_HZ 40000000
`define RCS_BAUD_19200 32'h00004B00
`define RCS_BAUD_9600 32'h00002580
`define RCS_BAUD_4800 32'h000012C0
`define RCS_BAUD_2400 32'h00000960
`define RCS_DIV_19200 (`RCS_CLK_HZ / `RCS_BAUD_19200)
`define RCS_DIV_9600 (`RCS_CLK_HZ / `RCS_BAUD_9600)
`define RCS_DIV_4800 (`RCS_CLK_HZ / `RCS_BAUD_4800)
`define RCS_DIV_2400 (`RCS_CLK_HZ / `RCS_BAUD_2400)

`endif

// >>> rtl/rcs_event_latch.sv
`timescale 1ns/1ps
module rcs_event_latch #(
	parameter logic [15:0] LATCH_MASK = 16'hFFFF
) (
	// clock and reset
	input wire logic hclk,
	input wire logic hresetn,
	// condition in, read clear
	input wire logic [15:0] cond,
	input wire logic clr,
	input wire logic [15:0] mask,
	// latched events and summary
	output logic [15:0] event_bits,
	output logic summary
);
	import rcs_pkg::*;

	rcs_latch_t r_reg;
	rcs_latch_t r_next;

	always_comb begin
		r_next = r_reg;
		r_next.prev = cond;
		// rising condition sets, and a set beats a same-cycle clear
		r_next.evt = (clr ? 16'h0000 : r_reg.evt) | (cond & ~r_reg.prev & LATCH_MASK);
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			r_reg <= '0;
		end else begin
			r_reg <= r_next;
		end
	end

	assign event_bits = r_reg.evt;
	assign summary = |(r_reg.evt & mask);
endmodule

// >>> rtl/rcs_pkg.sv
package rcs_pkg;

	typedef enum logic [1:0] {
		BAUD_19200 = 2'b00,
		BAUD_9600 = 2'b01,
		BAUD_4800 = 2'b10,
		BAUD_2400 = 2'b11
	} rcs_baud_t;

	typedef struct packed {
		logic [15:0] prev;
		logic [15:0] evt;
	} rcs_latch_t;

	typedef struct packed {
		logic dsel;
		logic dwr;
		logic [7:0] daddr;
		logic [31:0] hrdata;
		logic [15:0] op_mask;
		logic [15:0] q_mask;
		logic nv_loaded;
		logic [4:0] bus_addr;
		logic [4:0] nv_addr;
		logic nv_save;
		logic dhcp;
		logic autoip;
		logic [31:0] ip;
		logic [31:0] mask;
		logic [6:0] index;
		logic name_def;
		rcs_baud_t baud;
		logic [15:0] div_cnt;
		logic baud_tick;
		logic echo_on;
		logic echo_stop;
		logic echo_valid;
		logic [7:0] echo_char;
	} rcs_state_t;

endpackage

// >>> rtl/rcs_top.sv
`timescale 1ns/1ps
`include "rcs_defs.svh"
// Contract
// - questionable mask bits gate questionable events
// - status bit three is masked questionable OR
// - questionable mask query returns stored mask
// - second event read without changes returns zero
// - entering constant current latches operation event 1024
// - constant voltage shows condition value 256
// - bus address 0 to 30 takes effect
// - address survives power cycle only after save
// - automatic addressing off selects static addresses; the code also needs dynamic configuration off
// - dynamic configuration on requests server address
// - static ip and mask applied only statically
// - hardware address reads zero without lan
// - lan restore sets defaults and free index
// - serial rate from four values, readable
// - echo on returns every received character
// - echo off stops after next terminator
// - general reset leaves echo untouched
// - reading questionable events clears them
// - only error bits 13 and 12 latch
// - status bit seven is masked operation OR
module rcs_top #(
	parameter int unsigned DIV_19200 = `RCS_DIV_19200,
	parameter int unsigned DIV_9600 = `RCS_DIV_9600,
	parameter int unsigned DIV_4800 = `RCS_DIV_4800,
	parameter int unsigned DIV_2400 = `RCS_DIV_2400
) (
	// clock and reset
	input wire logic hclk,
	input wire logic hresetn,
	// ahb-lite slave
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	// supply conditions
	input wire logic constant_voltage_flag,
	input wire logic constant_current_flag,
	input wire logic current_error_flag,
	input wire logic voltage_error_flag,
	input wire logic current_mode_error_flag,
	input wire logic voltage_mode_error_flag,
	// status byte summaries
	output logic operation_summary,
	output logic questionable_summary,
	// parallel bus address
	input wire logic [4:0] nv_bus_addr_in,
	output logic [4:0] bus_addr,
	output logic [4:0] nv_bus_addr_out,
	output logic save_settings_command,
	// lan settings
	input wire logic lan_fitted,
	input wire logic [47:0] mac_addr,
	input wire logic [6:0] lan_free_index,
	output logic lan_dhcp_en,
	output logic lan_auto_en,
	output logic lan_use_static,
	output logic [31:0] lan_ip,
	output logic [31:0] lan_mask,
	output logic [6:0] lan_index,
	output logic lan_defaults_restore_command,
	// serial port
	input wire logic general_reset,
	input wire logic rx_valid,
	input wire logic [7:0] rx_char,
	output logic echo_valid,
	output logic [7:0] echo_char,
	output logic baud_tick,
	output rcs_pkg::rcs_baud_t baud_sel
);
	import rcs_pkg::*;

	localparam rcs_state_t ST_RST = '{
		dhcp: 1'b1,
		autoip: 1'b1,
		index: `RCS_RST_INDEX,
		bus_addr: `RCS_RST_BUS_ADDR,
		nv_addr: `RCS_RST_BUS_ADDR,
		baud: BAUD_19200,
		default: '0
	};

	rcs_state_t r_reg;
	rcs_state_t r_next;

	logic acc;
	logic rd_acc;
	logic op_clr;
	logic q_clr;
	logic [15:0] op_cond;
	logic [15:0] q_cond;
	logic [15:0] op_event;
	logic [15:0] q_event;
	logic op_sum;
	logic q_sum;
	logic [7:0] status_byte;

	// address phase taken when hsel, hready and htrans[1] are all high
	assign acc = hsel & hready & htrans[1];
	assign rd_acc = acc & ~hwrite;
	assign op_clr = rd_acc & (haddr[7:0] == `RCS_OFF_OPER_EVENT);
	assign q_clr = rd_acc & (haddr[7:0] == `RCS_OFF_QUES_EVENT);

	always_comb begin
		op_cond = 16'h0000;
		op_cond[`RCS_OPER_CV_BIT] = constant_voltage_flag;
		op_cond[`RCS_OPER_CC_BIT] = constant_current_flag;
	end

	always_comb begin
		q_cond = 16'h0000;
		q_cond[`RCS_QUES_VM_BIT] = voltage_mode_error_flag;
		q_cond[`RCS_QUES_CM_BIT] = current_mode_error_flag;
		q_cond[`RCS_QUES_VE_BIT] = voltage_error_flag;
		q_cond[`RCS_QUES_CE_BIT] = current_error_flag;
	end

	rcs_event_latch #(
		.LATCH_MASK(`RCS_OPER_LATCH)
	) u_oper (
		.hclk(hclk),
		.hresetn(hresetn),
		.cond(op_cond),
		.clr(op_clr),
		.mask(r_reg.op_mask),
		.event_bits(op_event),
		.summary(op_sum)
	);

	// only the two error bits latch
	rcs_event_latch #(
		.LATCH_MASK(`RCS_QUES_LATCH)
	) u_ques (
		.hclk(hclk),
		.hresetn(hresetn),
		.cond(q_cond),
		.clr(q_clr),
		.mask(r_reg.q_mask),
		.event_bits(q_event),
		.summary(q_sum)
	);

	always_comb begin
		status_byte = 8'h00;
		status_byte[`RCS_SB_QUES_BIT] = q_sum;
		status_byte[`RCS_SB_OPER_BIT] = op_sum;
	end

	function automatic logic [31:0] baud_word(input rcs_baud_t b);
		logic [31:0] w;
		w = `RCS_BAUD_19200;
		unique case (b)
			BAUD_19200: w = `RCS_BAUD_19200;
			BAUD_9600: w = `RCS_BAUD_9600;
			BAUD_4800: w = `RCS_BAUD_4800;
			BAUD_2400: w = `RCS_BAUD_2400;
		endcase
		return w;
	endfunction

	function automatic logic [15:0] baud_div(input rcs_baud_t b);
		logic [15:0] d;
		d = DIV_19200[15:0];
		unique case (b)
			BAUD_19200: d = DIV_19200[15:0];
			BAUD_9600: d = DIV_9600[15:0];
			BAUD_4800: d = DIV_4800[15:0];
			BAUD_2400: d = DIV_2400[15:0];
		endcase
		return d;
	endfunction

	function automatic logic [31:0] rd_word(input logic [7:0] a);
		logic [31:0] w;
		w = 32'h00000000;
		case (a)
			`RCS_OFF_OPER_COND: w = {16'h0000, op_cond};
			`RCS_OFF_OPER_EVENT: w = {16'h0000, op_event};
			`RCS_OFF_OPER_MASK: w = {16'h0000, r_reg.op_mask};
			`RCS_OFF_QUES_COND: w = {16'h0000, q_cond};
			`RCS_OFF_QUES_EVENT: w = {16'h0000, q_event};
			`RCS_OFF_QUES_MASK: w = {16'h0000, r_reg.q_mask};
			`RCS_OFF_STATUS_BYTE: w = {24'h000000, status_byte};
			`RCS_OFF_BUS_ADDR: w = {27'h0000000, r_reg.bus_addr};
			`RCS_OFF_LAN_CTRL: w = {30'h00000000, r_reg.autoip, r_reg.dhcp};
			`RCS_OFF_LAN_IP: w = r_reg.ip;
			`RCS_OFF_LAN_MASK: w = r_reg.mask;
			`RCS_OFF_MAC_LO: w = lan_fitted ? mac_addr[31:0] : 32'h00000000;
			`RCS_OFF_MAC_HI: w = lan_fitted ? {16'h0000, mac_addr[47:32]} : 32'h00000000;
			`RCS_OFF_LAN_INDEX: w = {25'h0000000, r_reg.index};
			`RCS_OFF_SER_BAUD: w = baud_word(r_reg.baud);
			`RCS_OFF_SER_ECHO: w = {31'h00000000, r_reg.echo_on & ~r_reg.echo_stop};
			default: w = 32'h00000000;
		endcase
		return w;
	endfunction

	always_comb begin
		logic [15:0] div;
		logic [31:0] wd;
		div = baud_div(r_reg.baud);
		wd = hwdata;
		r_next = r_reg;
		r_next.nv_save = 1'b0;
		r_next.name_def = 1'b0;
		r_next.echo_valid = 1'b0;
		r_next.baud_tick = 1'b0;

		// address phase capture and read data
		if (hready) begin
			r_next.dsel = acc;
			r_next.dwr = hwrite;
			r_next.daddr = haddr[7:0];
		end
		if (rd_acc) begin
			r_next.hrdata = rd_word(haddr[7:0]);
		end

		// stored address picked up once after reset release
		if (!r_reg.nv_loaded) begin
			r_next.nv_loaded = 1'b1;
			if (nv_bus_addr_in <= `RCS_BUS_ADDR_MAX) begin
				r_next.bus_addr = nv_bus_addr_in;
				r_next.nv_addr = nv_bus_addr_in;
			end
		end

		// general reset clears the masks; echo state is not touched
		if (general_reset) begin
			r_next.op_mask = 16'h0000;
			r_next.q_mask = 16'h0000;
		end

		// baud rate enable pulse
		if (r_reg.div_cnt >= div - 16'h0001) begin
			r_next.div_cnt = 16'h0000;
			r_next.baud_tick = 1'b1;
		end else begin
			r_next.div_cnt = r_reg.div_cnt + 16'h0001;
		end

		// character echo
		if (rx_valid && r_reg.echo_on) begin
			r_next.echo_valid = 1'b1;
			r_next.echo_char = rx_char;
			if (r_reg.echo_stop && rx_char == `RCS_LINE_TERM) begin
				r_next.echo_on = 1'b0;
				r_next.echo_stop = 1'b0;
			end
		end

		// data phase writes
		if (r_reg.dsel && r_reg.dwr) begin
			case (r_reg.daddr)
				`RCS_OFF_OPER_MASK: r_next.op_mask = wd[15:0];
				`RCS_OFF_QUES_MASK: r_next.q_mask = wd[15:0];
				`RCS_OFF_BUS_ADDR: begin
					if (wd[31:5] == 27'h0000000 && wd[4:0] <= `RCS_BUS_ADDR_MAX) begin
						r_next.bus_addr = wd[4:0];
					end
				end
				`RCS_OFF_COMMAND: begin
					if (wd[`RCS_CMD_SAVE_BIT]) begin
						r_next.nv_addr = r_reg.bus_addr;
						r_next.nv_save = 1'b1;
					end
					if (wd[`RCS_CMD_LAN_RST_BIT]) begin
						r_next.dhcp = 1'b1;
						r_next.autoip = 1'b1;
						r_next.name_def = 1'b1;
						if (lan_free_index >= `RCS_INDEX_MIN && lan_free_index <= `RCS_INDEX_MAX) begin
							r_next.index = lan_free_index;
						end else begin
							r_next.index = `RCS_RST_INDEX;
						end
					end
				end
				`RCS_OFF_LAN_CTRL: begin
					r_next.dhcp = wd[`RCS_LAN_DHCP_BIT];
					r_next.autoip = wd[`RCS_LAN_AUTO_BIT];
				end
				`RCS_OFF_LAN_IP: r_next.ip = wd;
				`RCS_OFF_LAN_MASK: r_next.mask = wd;
				`RCS_OFF_LAN_INDEX: begin
					if (wd[31:7] == 25'h0000000 && wd[6:0] >= `RCS_INDEX_MIN && wd[6:0] <= `RCS_INDEX_MAX) begin
						r_next.index = wd[6:0];
					end
				end
				`RCS_OFF_SER_BAUD: begin
					r_next.div_cnt = 16'h0000;
					case (wd)
						`RCS_BAUD_19200: r_next.baud = BAUD_19200;
						`RCS_BAUD_9600: r_next.baud = BAUD_9600;
						`RCS_BAUD_4800: r_next.baud = BAUD_4800;
						`RCS_BAUD_2400: r_next.baud = BAUD_2400;
						default: r_next.div_cnt = r_next.div_cnt;
					endcase
					if (baud_word(r_next.baud) == baud_word(r_reg.baud)) begin
						r_next.div_cnt = r_reg.div_cnt + 16'h0001;
						if (r_reg.div_cnt >= div - 16'h0001) begin
							r_next.div_cnt = 16'h0000;
						end
					end
				end
				`RCS_OFF_SER_ECHO: begin
					if (wd[0]) begin
						r_next.echo_on = 1'b1;
						r_next.echo_stop = 1'b0;
					end else if (r_reg.echo_on) begin
						r_next.echo_stop = 1'b1;
					end
				end
				default: r_next.dsel = r_next.dsel;
			endcase
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			r_reg <= ST_RST;
		end else begin
			r_reg <= r_next;
		end
	end

	// zero wait state slave, always okay
	assign hreadyout = 1'b1;
	assign hresp = 1'b0;
	assign hrdata = r_reg.hrdata;

	assign operation_summary = op_sum;
	assign questionable_summary = q_sum;

	assign bus_addr = r_reg.bus_addr;
	assign nv_bus_addr_out = r_reg.nv_addr;
	assign save_settings_command = r_reg.nv_save;

	assign lan_dhcp_en = r_reg.dhcp;
	assign lan_auto_en = r_reg.autoip;
	assign lan_use_static = ~r_reg.dhcp & ~r_reg.autoip;
	assign lan_ip = r_reg.ip;
	assign lan_mask = r_reg.mask;
	assign lan_index = r_reg.index;
	assign lan_defaults_restore_command = r_reg.name_def;

	assign echo_valid = r_reg.echo_valid;
	assign echo_char = r_reg.echo_char;
	assign baud_tick = r_reg.baud_tick;
	assign baud_sel = r_reg.baud;
endmodule

// >>> testbench/rcs_assertions.sv
`timescale 1ns/1ps
module rcs_checker (
	// clock and reset
	input wire logic hclk,
	input wire logic hresetn,
	// serial
	input wire logic rx_valid,
	input wire logic [7:0] rx_char,
	input wire logic echo_valid,
	input wire logic [7:0] echo_char,
	input wire logic baud_tick,
	input wire logic general_reset,
	// address and lan
	input wire logic [4:0] bus_addr,
	input wire logic save_settings_command,
	input wire logic lan_dhcp_en,
	input wire logic lan_auto_en,
	input wire logic lan_use_static,
	input wire logic [6:0] lan_index,
	input wire logic lan_defaults_restore_command,
	// summaries
	input wire logic operation_summary,
	input wire logic questionable_summary
);
	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);
	sequence lan_dflt;
		lan_dhcp_en && lan_auto_en && lan_index inside {[7'h01:7'h63]};
	endsequence
	sequence tick_quiet;
		!baud_tick [*2];
	endsequence
	echo_pair_a: assert property (echo_valid |-> $past(rx_valid) && echo_char == $past(rx_char))
		else $error("echo without matching received char");
	addr_range_a: assert property (bus_addr <= 5'h1E)
		else $error("bus address above 30");
	static_sel_a: assert property (lan_use_static == (!lan_dhcp_en && !lan_auto_en))
		else $error("static address selection wrong");
	index_range_a: assert property (lan_index inside {[7'h01:7'h63]})
		else $error("lan index outside 1 to 99");
	restore_def_a: assert property (lan_defaults_restore_command |-> ##[0:1] lan_dflt)
		else $error("lan defaults not restored");
	tick_gap_a: assert property (baud_tick |=> tick_quiet)
		else $error("baud ticks too close");
	mask_clear_a: assert property (general_reset |=> !questionable_summary && !operation_summary)
		else $error("summary set with cleared masks");
	save_pulse_a: assert property (save_settings_command |=> !save_settings_command)
		else $error("save command longer than one cycle");
endmodule

// >>> testbench/rcs_nv_store.sv
`timescale 1ns/1ps
module rcs_nv_store (
	// clock
	input wire logic hclk,
	// device side
	input wire logic save_settings_command,
	input wire logic [4:0] nv_bus_addr_out,
	output logic [4:0] nv_bus_addr_in,
	output logic [6:0] lan_free_index
);
	logic save_d = 1'b0;
	logic [4:0] store_reg = 5'h00;
	// keeps its content across device resets, written only on save
	assign nv_bus_addr_in = store_reg;
	assign lan_free_index = 7'h2A;
	always @(posedge hclk) begin
		save_d <= save_settings_command;
		if (save_settings_command || save_d) begin
			store_reg <= nv_bus_addr_out;
		end
	end
endmodule

// >>> testbench/rcs_top_tb.sv
`timescale 1ns/1ps
`include "rcs_defs.svh"
`define CHK(nm, e, a) begin total_checks++; if ((a) !== (e)) begin n_fail++; $display("[ERR] %s exp %0h got %0h", nm, e, a); end end
module rcs_top_tb;
	import rcs_pkg::*;
	logic hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, hreadyout, hresp;
	logic [31:0] haddr = 0, hwdata = 0, hrdata, lan_ip, lan_mask, r;
	logic [1:0] htrans = 0;
	logic [2:0] hsize = 3'h2;
	logic cvf = 1, ccf = 0, cef = 0, vef = 0, cmf = 0, vmf = 0, osum, qsum;
	logic [4:0] nv_in, bus_addr, nv_out;
	logic save, lan_fitted = 1, dhcp, auto, stat, restore, gen_rst = 0, rx_valid = 0, echo_valid, tick;
	logic [47:0] mac = 48'h0123456789AB;
	logic [6:0] free_idx, lan_index;
	logic [7:0] rx_char = 0, echo_char;
	rcs_baud_t baud_sel;
	logic [31:0] rates [4] = '{32'h4B00, 32'h2580, 32'h12C0, 32'h0960};
	int n_fail = 0, total_checks = 0, cyc;
	always #12.5 hclk = ~hclk;
	rcs_top #(.DIV_19200(4), .DIV_9600(6), .DIV_4800(8), .DIV_2400(10)) i_dut (.hclk(hclk), .hresetn(hresetn),
		.hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
		.hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
		.constant_voltage_flag(cvf), .constant_current_flag(ccf), .current_error_flag(cef),
		.voltage_error_flag(vef), .current_mode_error_flag(cmf), .voltage_mode_error_flag(vmf),
		.operation_summary(osum), .questionable_summary(qsum), .nv_bus_addr_in(nv_in), .bus_addr(bus_addr),
		.nv_bus_addr_out(nv_out), .save_settings_command(save), .lan_fitted(lan_fitted), .mac_addr(mac),
		.lan_free_index(free_idx), .lan_dhcp_en(dhcp), .lan_auto_en(auto), .lan_use_static(stat),
		.lan_ip(lan_ip), .lan_mask(lan_mask), .lan_index(lan_index), .lan_defaults_restore_command(restore),
		.general_reset(gen_rst), .rx_valid(rx_valid), .rx_char(rx_char), .echo_valid(echo_valid),
		.echo_char(echo_char), .baud_tick(tick), .baud_sel(baud_sel));
	rcs_nv_store i_nv (.hclk(hclk), .save_settings_command(save), .nv_bus_addr_out(nv_out),
		.nv_bus_addr_in(nv_in), .lan_free_index(free_idx));
	// outputs read at an edge show what stood in the cycle before it
	task automatic tk(input int n);
		repeat (n) @(posedge hclk);
	endtask
	task automatic xfer(input [7:0] a, input w, input [31:0] d);
		hsel <= 1'b1;
		haddr <= {24'h0, a};
		htrans <= 2'h2;
		hwrite <= w;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		r = hrdata;
	endtask
	task automatic rd(input [7:0] a, input [31:0] e);
		xfer(a, 1'b0, 32'h0);
		`CHK("read", e, r)
	endtask
	task automatic snd(input [7:0] c, input e);
		rx_valid <= 1'b1;
		rx_char <= c;
		tk(1);
		rx_valid <= 1'b0;
		tk(1);
		`CHK("echo", e, echo_valid)
		if (e) `CHK("echo char", c, echo_char)
	endtask
	task automatic pwr();
		hresetn <= 1'b0;
		tk(3);
		hresetn <= 1'b1;
		tk(2);
	endtask
	task automatic complete_run();
		$display("checks %0d failures %0d", total_checks, n_fail);
		if (n_fail == 0 && total_checks > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask
	initial begin
		repeat (20000) @(posedge hclk);
		n_fail++;
		complete_run();
	end
	initial begin
		tk(3);
		hresetn <= 1'b1;
		tk(1);
		rd(`RCS_OFF_SER_BAUD, 32'h4B00);
		rd(`RCS_OFF_LAN_CTRL, 32'h3);
		xfer(`RCS_OFF_QUES_MASK, 1'b1, 32'h3000);
		rd(`RCS_OFF_QUES_MASK, 32'h3000);
		cef <= 1'b1;
		cmf <= 1'b1;
		tk(2);
		`CHK("ques sum", 1'b1, qsum)
		rd(`RCS_OFF_QUES_COND, 32'h2002);
		cef <= 1'b0;
		cmf <= 1'b0;
		rd(`RCS_OFF_QUES_EVENT, 32'h2000);
		rd(`RCS_OFF_QUES_EVENT, 32'h0);
		`CHK("ques sum", 1'b0, qsum)
		xfer(`RCS_OFF_QUES_MASK, 1'b1, 32'h0);
		vef <= 1'b1;
		tk(2);
		vef <= 1'b0;
		`CHK("ques masked", 1'b0, qsum)
		rd(`RCS_OFF_QUES_EVENT, 32'h1000);
		rd(`RCS_OFF_OPER_COND, 32'h100);
		rd(`RCS_OFF_OPER_EVENT, 32'h100);
		xfer(`RCS_OFF_OPER_MASK, 1'b1, 32'h0500);
		cvf <= 1'b0;
		ccf <= 1'b1;
		tk(2);
		`CHK("oper sum", 1'b1, osum)
		rd(`RCS_OFF_STATUS_BYTE, 32'h80);
		rd(`RCS_OFF_OPER_EVENT, 32'h400);
		rd(`RCS_OFF_OPER_EVENT, 32'h0);
		xfer(`RCS_OFF_BUS_ADDR, 1'b1, 32'h1E);
		xfer(`RCS_OFF_BUS_ADDR, 1'b1, 32'h1F);
		rd(`RCS_OFF_BUS_ADDR, 32'h1E);
		`CHK("bus addr", 5'h1E, bus_addr)
		pwr();
		`CHK("unsaved addr", 5'h00, bus_addr)
		xfer(`RCS_OFF_BUS_ADDR, 1'b1, 32'h1E);
		xfer(`RCS_OFF_COMMAND, 1'b1, 32'h1);
		tk(2);
		`CHK("nv addr", 5'h1E, nv_out)
		pwr();
		`CHK("saved addr", 5'h1E, bus_addr)
		xfer(`RCS_OFF_LAN_CTRL, 1'b1, 32'h0);
		xfer(`RCS_OFF_LAN_IP, 1'b1, 32'hC0A80001);
		xfer(`RCS_OFF_LAN_MASK, 1'b1, 32'hFFFFFF00);
		tk(1);
		`CHK("static", 1'b1, stat)
		`CHK("ip", 32'hC0A80001, lan_ip)
		`CHK("mask", 32'hFFFFFF00, lan_mask)
		rd(`RCS_OFF_LAN_MASK, 32'hFFFFFF00);
		xfer(`RCS_OFF_LAN_CTRL, 1'b1, 32'h1);
		tk(1);
		`CHK("dhcp", 1'b0, stat)
		`CHK("dhcp on", 1'b1, dhcp)
		`CHK("auto off", 1'b0, auto)
		xfer(`RCS_OFF_COMMAND, 1'b1, 32'h2);
		tk(1);
		`CHK("restore", 1'b1, restore)
		rd(`RCS_OFF_LAN_CTRL, 32'h3);
		`CHK("auto on", 1'b1, auto)
		`CHK("index", 7'h2A, lan_index)
		rd(`RCS_OFF_MAC_LO, mac[31:0]);
		rd(`RCS_OFF_MAC_HI, {16'h0, mac[47:32]});
		lan_fitted <= 1'b0;
		tk(1);
		rd(`RCS_OFF_MAC_LO, 32'h0);
		rd(`RCS_OFF_MAC_HI, 32'h0);
		// divider counts set at the instance: 4, 6, 8, 10
		for (int i = 0; i < 4; i++) begin
			xfer(`RCS_OFF_SER_BAUD, 1'b1, rates[i]);
			rd(`RCS_OFF_SER_BAUD, rates[i]);
			`CHK("baud sel", rcs_baud_t'(i[1:0]), baud_sel)
			cyc = 0;
			do begin
				tk(1);
				cyc++;
			end while (tick !== 1'b1 && cyc < 40);
			cyc = 0;
			do begin
				tk(1);
				cyc++;
			end while (tick !== 1'b1 && cyc < 40);
			`CHK("tick period", 4 + 2 * i, cyc)
		end
		xfer(`RCS_OFF_SER_BAUD, 1'b1, 32'h04D2);
		rd(`RCS_OFF_SER_BAUD, 32'h0960);
		snd(8'h41, 1'b0);
		xfer(`RCS_OFF_SER_ECHO, 1'b1, 32'h1);
		snd(8'h42, 1'b1);
		gen_rst <= 1'b1;
		tk(1);
		gen_rst <= 1'b0;
		rd(`RCS_OFF_SER_ECHO, 32'h1);
		xfer(`RCS_OFF_SER_ECHO, 1'b1, 32'h0);
		rd(`RCS_OFF_SER_ECHO, 32'h0);
		snd(8'h43, 1'b1);
		snd(8'h0A, 1'b1);
		snd(8'h44, 1'b0);
		complete_run();
	end
endmodule
bind rcs_top rcs_checker i_chk (.hclk(hclk), .hresetn(hresetn), .rx_valid(rx_valid), .rx_char(rx_char),
	.echo_valid(echo_valid), .echo_char(echo_char), .baud_tick(baud_tick), .general_reset(general_reset),
	.bus_addr(bus_addr), .save_settings_command(save_settings_command), .lan_dhcp_en(lan_dhcp_en),
	.lan_auto_en(lan_auto_en), .lan_use_static(lan_use_static), .lan_index(lan_index),
	.lan_defaults_restore_command(lan_defaults_restore_command), .operation_summary(operation_summary),
	.questionable_summary(questionable_summary));
